// *** shared/regulator_control_pkg.sv ***
`default_nettype none
package regulator_control_pkg;

   // register addresses on the documented register port
   localparam logic [7:0] ADDR_LINREG_D_TARGET = 8'h07;
   localparam logic [7:0] ADDR_CURRENT_LIMITS  = 8'h08;
   localparam logic [7:0] ADDR_ENABLE_MODE     = 8'h09;

   // reset values
   localparam logic [7:0] RESET_LINREG_D_TARGET = 8'h00;
   localparam logic [7:0] RESET_CURRENT_LIMITS  = 8'h55;
   localparam logic [7:0] RESET_ENABLE_MODE     = 8'h00;

   // writable bits of each register
   localparam logic [7:0] MASK_LINREG_D_TARGET = 8'h7f;
   localparam logic [7:0] MASK_CURRENT_LIMITS  = 8'h55;
   localparam logic [7:0] MASK_ENABLE_MODE     = 8'hdf;

   // field positions
   localparam int LIMIT_A_BIT   = 0;
   localparam int LIMIT_B_BIT   = 2;
   localparam int LIMIT_C_BIT   = 4;
   localparam int LIMIT_D_BIT   = 6;
   localparam int EN_A_BIT      = 0;
   localparam int EN_B_BIT      = 1;
   localparam int EN_C_BIT      = 2;
   localparam int EN_D_BIT      = 3;
   localparam int EN_DOWN_BIT   = 4;
   localparam int DOWN_PWM_BIT  = 6;
   localparam int UP_PWM_BIT    = 7;

   // target code table, millivolts
   localparam logic [6:0]  CODE_DEFAULT   = 7'h00;
   localparam logic [6:0]  CODE_BASE      = 7'h0f;
   localparam logic [6:0]  CODE_LAST      = 7'h73;
   localparam logic [15:0] MV_AT_BASE     = 16'h0320;
   localparam logic [15:0] MV_STEP        = 16'h0019;
   localparam logic [15:0] MV_DEFAULT_OUT = 16'h0000;

   localparam logic [2:0] SLOT_SOFTWARE = 3'h0;

   typedef struct packed {
      logic [2:0] down;
      logic [2:0] lin_d;
      logic [2:0] lin_c;
      logic [2:0] lin_b;
      logic [2:0] lin_a;
   } slot_select_type;

   typedef struct packed {
      logic down;
      logic lin_d;
      logic lin_c;
      logic lin_b;
      logic lin_a;
   } output_on_type;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_access_type;

endpackage
`default_nettype wire

// *** src/target_code_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module target_code_decode
   import regulator_control_pkg::*;
(
   input  wire logic [6:0]  code,
   output logic      [15:0] millivolts,
   output logic             code_valid,
   output logic             code_default
);

   always_comb
   begin
      code_default = (code == CODE_DEFAULT);
      code_valid   = (code >= CODE_BASE) && (code <= CODE_LAST);
      if (code_valid)
      begin
         millivolts = 16'(MV_AT_BASE + MV_STEP * 16'(code - CODE_BASE));
      end
      else
      begin
         millivolts = MV_DEFAULT_OUT;
      end
   end

endmodule
`default_nettype wire

// *** src/regulator_control_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module regulator_control_regs
   import regulator_control_pkg::*;
(
   input  wire logic            mclk,
   input  wire logic            sys_rst,
   input  wire logic            clk_en,
   input  wire reg_access_type  access,
   input  wire slot_select_type slot_select,
   input  wire output_on_type   seq_on,
   output logic      [7:0]      rdata,
   output logic                 rdata_valid,
   output var output_on_type    output_on,
   output logic                 step_up_pwm_force,
   output logic                 step_down_pwm_force,
   output logic      [3:0]      limit_high,
   output logic      [6:0]      linreg_d_target_code,
   output logic      [15:0]     linreg_d_millivolts,
   output logic                 linreg_d_code_valid
);

   logic [7:0]    target_reg;
   logic [7:0]    limit_reg;
   logic [7:0]    enable_reg;
   logic [7:0]    next_target_reg;
   logic [7:0]    next_limit_reg;
   logic [7:0]    next_enable_reg;
   logic [7:0]    next_rdata;
   logic          next_rdata_valid;
   output_on_type next_output_on;
   logic [15:0]   decoded_mv;
   logic          decoded_valid;

   function automatic logic [7:0] masked_write(input logic [7:0] old_value,
                                               input logic [7:0] new_value,
                                               input logic [7:0] mask);
      masked_write = (new_value & mask) | (old_value & ~mask);
   endfunction

   function automatic logic pick_on(input logic [2:0] slot, input logic sw_bit,
                                    input logic seq_bit);
      pick_on = (slot == SLOT_SOFTWARE) ? sw_bit : seq_bit;
   endfunction

   target_code_decode u_decode
   (
      .code         (target_reg[6:0]),
      .millivolts   (decoded_mv),
      .code_valid   (decoded_valid),
      .code_default ()
   );

   always_comb
   begin
      next_target_reg  = target_reg;
      next_limit_reg   = limit_reg;
      next_enable_reg  = enable_reg;
      next_rdata       = rdata;
      next_rdata_valid = 1'b0;
      if (access.wr)
      begin
         case (access.addr)
            ADDR_LINREG_D_TARGET:
               next_target_reg = masked_write(target_reg, access.wdata, MASK_LINREG_D_TARGET);
            ADDR_CURRENT_LIMITS:
               next_limit_reg = masked_write(limit_reg, access.wdata, MASK_CURRENT_LIMITS);
            ADDR_ENABLE_MODE:
               next_enable_reg = masked_write(enable_reg, access.wdata, MASK_ENABLE_MODE);
            default:
               next_target_reg = target_reg;
         endcase
      end
      if (access.rd)
      begin
         next_rdata_valid = 1'b1;
         case (access.addr)
            ADDR_LINREG_D_TARGET: next_rdata = target_reg & MASK_LINREG_D_TARGET;
            ADDR_CURRENT_LIMITS:  next_rdata = limit_reg & MASK_CURRENT_LIMITS;
            ADDR_ENABLE_MODE:     next_rdata = enable_reg & MASK_ENABLE_MODE;
            default:              next_rdata = 8'h00;
         endcase
      end
   end

   always_comb
   begin
      next_output_on.down  = pick_on(slot_select.down, enable_reg[EN_DOWN_BIT], seq_on.down);
      next_output_on.lin_d = pick_on(slot_select.lin_d, enable_reg[EN_D_BIT], seq_on.lin_d);
      next_output_on.lin_c = pick_on(slot_select.lin_c, enable_reg[EN_C_BIT], seq_on.lin_c);
      next_output_on.lin_b = pick_on(slot_select.lin_b, enable_reg[EN_B_BIT], seq_on.lin_b);
      next_output_on.lin_a = pick_on(slot_select.lin_a, enable_reg[EN_A_BIT], seq_on.lin_a);
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         target_reg  <= RESET_LINREG_D_TARGET;
         limit_reg   <= RESET_CURRENT_LIMITS;
         enable_reg  <= RESET_ENABLE_MODE;
         rdata       <= 8'h00;
         rdata_valid <= 1'b0;
      end
      else if (clk_en)
      begin
         target_reg  <= next_target_reg;
         limit_reg   <= next_limit_reg;
         enable_reg  <= next_enable_reg;
         rdata       <= next_rdata;
         rdata_valid <= next_rdata_valid;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         output_on           <= '0;
         step_up_pwm_force   <= 1'b0;
         step_down_pwm_force <= 1'b0;
         limit_high          <= 4'h0;
         linreg_d_target_code <= 7'h00;
         linreg_d_millivolts <= 16'h0000;
         linreg_d_code_valid <= 1'b0;
      end
      else if (clk_en)
      begin
         output_on           <= next_output_on;
         step_up_pwm_force   <= enable_reg[UP_PWM_BIT];
         step_down_pwm_force <= enable_reg[DOWN_PWM_BIT];
         limit_high          <= {limit_reg[LIMIT_D_BIT], limit_reg[LIMIT_C_BIT],
                                 limit_reg[LIMIT_B_BIT], limit_reg[LIMIT_A_BIT]};
         linreg_d_target_code <= target_reg[6:0];
         linreg_d_millivolts <= decoded_mv;
         linreg_d_code_valid <= decoded_valid;
      end
   end

   a_down_sw_enable: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && slot_select.down == SLOT_SOFTWARE
      |=> output_on.down == $past(enable_reg[EN_DOWN_BIT]))
      else $error("step-down enable does not follow software bit");

   a_lin_d_slot: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && slot_select.lin_d != SLOT_SOFTWARE
      |=> output_on.lin_d == $past(seq_on.lin_d))
      else $error("regulator d not handed to sequencer");

   a_lin_c_enable: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && slot_select.lin_c == SLOT_SOFTWARE
      |=> output_on.lin_c == $past(enable_reg[EN_C_BIT]))
      else $error("regulator c enable wrong");

   a_lin_b_enable: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && slot_select.lin_b == SLOT_SOFTWARE
      |=> output_on.lin_b == $past(enable_reg[EN_B_BIT]))
      else $error("regulator b enable wrong");

   a_lin_a_enable: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && slot_select.lin_a == SLOT_SOFTWARE
      |=> output_on.lin_a == $past(enable_reg[EN_A_BIT]))
      else $error("regulator a enable wrong");

   a_unused_zero: assert property (@(posedge mclk) disable iff (sys_rst)
      ((target_reg & ~MASK_LINREG_D_TARGET) == 8'h00)
      && ((limit_reg & ~MASK_CURRENT_LIMITS) == 8'h00)
      && ((enable_reg & ~MASK_ENABLE_MODE) == 8'h00))
      else $error("unused register bit is set");

   a_top_code_mv: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && target_reg[6:0] == CODE_LAST |=> linreg_d_millivolts == 16'h0ce4)
      else $error("top code does not give 3.3 V");

   // write of bit 7 reaches pin
   a_up_pwm_write: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && access.wr && access.addr == ADDR_ENABLE_MODE ##1 clk_en
      |=> step_up_pwm_force == $past(access.wdata[UP_PWM_BIT], 2))
      else $error("step-up pwm force does not follow write");

   a_down_pwm: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en |=> step_down_pwm_force == $past(enable_reg[DOWN_PWM_BIT]))
      else $error("step-down pwm force wrong");

endmodule
`default_nettype wire

// *** verif/reg_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module reg_host_model
   import regulator_control_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic [7:0] rdata,
   input  wire logic       rdata_valid,
   output var  reg_access_type access
);
   initial access = '0;

   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      logic [7:0] d;
      d = data;
      if (addr == ADDR_LINREG_D_TARGET && data[6:0] > CODE_LAST)
         d = {data[7], CODE_LAST};
      @(negedge mclk);
      access <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
      @(negedge mclk);
      access.wr    <= 1'b0;
      access.wdata <= ~d;
   endtask

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                           output logic valid);
      @(negedge mclk);
      access <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(negedge mclk);
      access.rd <= 1'b0;
      data  = rdata;
      valid = rdata_valid;
   endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import regulator_control_pkg::*;
   logic            mclk, sys_rst, clk_en;
   reg_access_type  access;
   slot_select_type slot_select;
   output_on_type   seq_on, output_on;
   logic [7:0]      rdata, v, en, last_en;
   logic            rdata_valid, up_pwm, down_pwm, code_ok;
   logic [3:0]      limit_high;
   logic [6:0]      code;
   logic [15:0]     mv;
   int              err_total, n_checks;
   integer          seed;
   logic [7:0]      rst_tab [4] = '{8'h00, 8'h55, 8'h00, 8'h00};
   logic [7:0]      ff_tab [4]  = '{8'h73, 8'h55, 8'hdf, 8'h00};
   logic [6:0]      corner [6]  = '{7'h00, 7'h0e, 7'h0f, 7'h24, 7'h33, 7'h73};

   regulator_control_regs dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
      .access(access), .slot_select(slot_select), .seq_on(seq_on), .rdata(rdata),
      .rdata_valid(rdata_valid), .output_on(output_on), .step_up_pwm_force(up_pwm),
      .step_down_pwm_force(down_pwm), .limit_high(limit_high),
      .linreg_d_target_code(code), .linreg_d_millivolts(mv),
      .linreg_d_code_valid(code_ok));
   reg_host_model host (.mclk(mclk), .rdata(rdata), .rdata_valid(rdata_valid),
      .access(access));

   always #10 mclk = ~mclk;

   function automatic logic [15:0] exp_mv(input logic [6:0] c);
      if (c >= 7'h0f && c <= 7'h73)
         return 16'h0320 + 16'h0019 * ({9'h000, c} - 16'h000f);
      return 16'h0000;
   endfunction

   function automatic output_on_type exp_on(input logic [7:0] e, input slot_select_type s,
                                            input output_on_type q);
      exp_on.down  = (s.down  == 3'h0) ? e[4] : q.down;
      exp_on.lin_d = (s.lin_d == 3'h0) ? e[3] : q.lin_d;
      exp_on.lin_c = (s.lin_c == 3'h0) ? e[2] : q.lin_c;
      exp_on.lin_b = (s.lin_b == 3'h0) ? e[1] : q.lin_b;
      exp_on.lin_a = (s.lin_a == 3'h0) ? e[0] : q.lin_a;
   endfunction

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: millivolts got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic ok;
      host.read_reg(a, v, ok);
      check_byte(v, exp, "read data");
      check_byte({7'h00, ok}, 8'h01, "read valid");
   endtask

   task automatic wr_settle(input logic [7:0] a, input logic [7:0] d);
      host.write_reg(a, d);
      @(negedge mclk);
   endtask

   task finish_test;
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #200000;
      err_total++;
      finish_test;
   end

   initial
   begin
      seed = 32'h0e4b1405;
      mclk = 1'b0;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      slot_select = '0;
      seq_on = '0;
      err_total = 0;
      n_checks = 0;
      repeat (4) @(posedge mclk);
      @(negedge mclk) sys_rst = 1'b0;
      repeat (2) @(negedge mclk);
      check_byte({4'h0, limit_high}, 8'h0f, "limit reset");
      for (int a = 0; a < 4; a++) rd_chk(8'h07 + 8'(a), rst_tab[a]);
      for (int a = 0; a < 4; a++) host.write_reg(8'h07 + 8'(a), 8'hff);
      for (int a = 0; a < 4; a++) rd_chk(8'h07 + 8'(a), ff_tab[a]);
      for (int i = 0; i < 5; i++)
      begin
         wr_settle(ADDR_CURRENT_LIMITS, (i < 4) ? 8'h01 << (2 * i) : 8'h00);
         check_byte({4'h0, limit_high}, (i < 4) ? 8'h01 << i : 8'h00, "limit");
      end
      for (int i = 0; i < 30; i++)
      begin
         v = (i < 6) ? {1'b0, corner[i]} : 8'h0f + 8'($unsigned($random(seed)) % 101);
         wr_settle(ADDR_LINREG_D_TARGET, v);
         check_byte({1'b0, code}, v, "code");
         check_word(mv, exp_mv(v[6:0]));
         check_byte({7'h00, code_ok}, {7'h00, v >= 8'h0f}, "code valid");
      end
      for (int i = 0; i < 40; i++)
      begin
         en = $random(seed);
         slot_select = 15'($random(seed) & $random(seed));
         seq_on = 5'($random(seed));
         wr_settle(ADDR_ENABLE_MODE, en);
         last_en = en & 8'hdf;
         check_byte({3'h0, output_on}, {3'h0, exp_on(en, slot_select, seq_on)}, "on");
         check_byte({6'h00, up_pwm, down_pwm}, {6'h00, en[7:6]}, "pwm");
      end
      rd_chk(ADDR_ENABLE_MODE, last_en);
      slot_select = '0;
      wr_settle(ADDR_ENABLE_MODE, 8'h1f);
      check_byte({3'h0, output_on}, 8'h1f, "all on");
      clk_en = 1'b0;
      host.write_reg(ADDR_ENABLE_MODE, 8'h00);
      clk_en = 1'b1;
      rd_chk(ADDR_ENABLE_MODE, 8'h1f);
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      check_byte({3'h0, output_on}, 8'h00, "on in reset");
      sys_rst = 1'b0;
      rd_chk(ADDR_ENABLE_MODE, RESET_ENABLE_MODE);
      rd_chk(ADDR_CURRENT_LIMITS, RESET_CURRENT_LIMITS);
      check_byte({4'h0, limit_high}, 8'h0f, "limit after reset");
      finish_test;
   end
endmodule
`default_nettype wire
